// ==== rtl/l1_hdlc_pkg.sv ====
// package: register map, field positions, codes and reset values for the layer-1/hdlc service block
package l1_hdlc_pkg;
    // ************************************************************
    // register indices (plain port, 8-bit data)
    // ************************************************************
    localparam logic [3:0] ADDR_ISTA = 4'h0;
    localparam logic [3:0] ADDR_EXTD = 4'h1;
    localparam logic [3:0] ADDR_CMDX = 4'h2;
    localparam logic [3:0] ADDR_CIRX = 4'h3;
    localparam logic [3:0] ADDR_TERM_ID_REG_FIRST = 4'h4;
    localparam logic [3:0] ADDR_TERM_ID_REG_SECOND = 4'h5;
    localparam logic [3:0] ADDR_SERVICE_POINT_REG_FIRST = 4'h6;
    localparam logic [3:0] ADDR_SERVICE_POINT_REG_SECOND = 4'h7;
    localparam logic [3:0] ADDR_SPRT = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'h9;
    localparam logic [3:0] ADDR_MODE = 4'hA;
    localparam logic [3:0] ADDR_STA2 = 4'hB;
    // ************************************************************
    // interrupt status bit positions, msb to lsb
    // ************************************************************
    localparam int ISTA_RXEND = 7;
    localparam int ISTA_POOLF = 6;
    localparam int ISTA_REMRX = 5;
    localparam int ISTA_TXRDY = 4;
    localparam int ISTA_TIMER = 3;
    localparam int ISTA_L1CHG = 2;
    localparam int ISTA_SYNC = 1;
    localparam int ISTA_EXT = 0;
    // extended register bits
    localparam int EXT_PROTERR = 0;
    // serial port control fields
    localparam int SP_TLOOP = 7;
    localparam int SP_BSEL_LO = 0;
    // mode register: auto mode bit
    localparam int MODE_AUTO = 0;
    // status bits
    localparam int STAT_TXBLK = 6;
    localparam int STA2_TIMER_RECOVERY_FLAG = 3;
    // ************************************************************
    // codes and reset values
    // ************************************************************
    localparam logic [3:0] CI_SOFT_RESET = 4'h1;
    localparam logic [3:0] CI_READY_IDLE = 4'h7;
    localparam logic [3:0] CI_DEACT_IDLE = 4'hF;
    localparam logic [3:0] CI_PEND_DEACT = 4'h0;
    localparam logic [3:0] CI_ACT_IND = 4'hC;
    localparam logic [3:0] CI_ACT_REQ = 4'h8;
    localparam logic [7:0] TEI_BROADCAST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam int RX_POOL_BYTES = 32;
    localparam logic [5:0] RX_POOL_CNT = 6'(RX_POOL_BYTES);
    localparam logic [1:0] BSEL_NETWORK = 2'h0;
    localparam logic [1:0] BSEL_SYNC = 2'h1;
    localparam logic [1:0] BSEL_SLOT = 2'h2;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } busreq_s;

    typedef struct packed {
        logic [7:0] ista;
        logic [7:0] ext;
        logic [3:0] ciTx;
        logic [3:0] ciRx;
        logic [7:0] term_id_reg_first;
        logic [7:0] term_id_reg_second;
        logic [7:0] service_point_reg_first;
        logic [7:0] service_point_reg_second;
        logic [7:0] sport;
        logic [7:0] mode;
        logic [5:0] rxCnt;
        logic [7:0] rdata;
        logic upOut;
        logic [1:0] bOut;
    } state_s;
endpackage

// ==== rtl/l1_hdlc_service.sv ====
// layer-1 command/indicate channel, hdlc event flags and serial port routing
// Operation
// - every indicate change raises layer-1 change; host reads state register
// - test-loop bit joins upstream data to downstream data
// - loop off returns layer 1 to normal deactivated state
// - port control routes b-channels to sync port, slot port or network
// - timer interrupt on hdlc timer expiry, only in auto mode
// - remote receiver change interrupt on remote receiver status change
// - extended interrupt summarises non-critical sources in extended register
// - pool-full interrupt at 32 bytes of unfinished frame
// - message-end interrupt on complete frame or long frame tail
// - status bits msb to lsb: end, full, remote, txrdy, timer, l1, sync, ext
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module l1_hdlc_service (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [3:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdata,
    output logic [3:0] commandIndicateCh0Tx,
    input wire logic [3:0] commandIndicateCh0Rx,
    input wire logic upstreamIn,
    output logic downstreamOut,
    input wire logic [1:0] bChanIn,
    output logic [1:0] bChanOut,
    input wire logic hdlcTimerTick,
    input wire logic remoteRxChange,
    input wire logic txPoolReady,
    input wire logic syncXferEvt,
    input wire logic [5:0] extEvt,
    input wire logic rxByte,
    input wire logic rxFrameEnd,
    input wire logic txFifoWriteEnable,
    input wire logic timerRecoveryFlag
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] ciMeta, ciSync, ciSyncD;
    logic upMeta, upSync;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ciMeta <= 4'h0;
            ciSync <= 4'h0;
            ciSyncD <= 4'h0;
            upMeta <= 1'b0;
            upSync <= 1'b0;
        end else if (clkEn) begin
            ciMeta <= commandIndicateCh0Rx;
            ciSync <= ciMeta;
            ciSyncD <= ciSync;
            upMeta <= upstreamIn;
            upSync <= upMeta;
        end
    end

    // ************************************************************
    // state
    // ************************************************************
    l1_hdlc_pkg::busreq_s req;
    l1_hdlc_pkg::state_s st_r, st_nxt;
    logic [7:0] istaSet;
    logic [7:0] extSet;
    logic rdIsta, rdExt, ciChanged;

    assign req = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
    // change seen on synchronised indication only
    assign ciChanged = (ciSync != ciSyncD);
    assign rdIsta = req.rd && (req.addr == l1_hdlc_pkg::ADDR_ISTA);
    assign rdExt = req.rd && (req.addr == l1_hdlc_pkg::ADDR_EXTD);

    always_comb begin
        st_nxt = st_r;
        istaSet = 8'h00;
        extSet = {2'b00, extEvt};
        // ************************************************************
        // event sources
        // ************************************************************
        istaSet[l1_hdlc_pkg::ISTA_L1CHG] = ciChanged;
        istaSet[l1_hdlc_pkg::ISTA_TIMER] = hdlcTimerTick && st_r.mode[l1_hdlc_pkg::MODE_AUTO];
        istaSet[l1_hdlc_pkg::ISTA_REMRX] = remoteRxChange;
        istaSet[l1_hdlc_pkg::ISTA_TXRDY] = txPoolReady;
        istaSet[l1_hdlc_pkg::ISTA_SYNC] = syncXferEvt;
        istaSet[l1_hdlc_pkg::ISTA_RXEND] = rxFrameEnd;
        if (rxFrameEnd) begin
            st_nxt.rxCnt = 6'h00;
        end else if (rxByte) begin
            if (st_r.rxCnt == l1_hdlc_pkg::RX_POOL_CNT - 6'h01) begin
                istaSet[l1_hdlc_pkg::ISTA_POOLF] = 1'b1;
                st_nxt.rxCnt = 6'h00;
            end else begin
                st_nxt.rxCnt = st_r.rxCnt + 6'h01;
            end
        end
        // ext register: read clears, a same-cycle event survives
        st_nxt.ext = (rdExt ? 8'h00 : st_r.ext) | extSet;
        istaSet[l1_hdlc_pkg::ISTA_EXT] = |st_nxt.ext;
        // status: read clears, set wins over clear
        st_nxt.ista = (rdIsta ? 8'h00 : st_r.ista) | istaSet;
        st_nxt.ciRx = ciSync;
        // ************************************************************
        // register writes
        // ************************************************************
        if (req.wr) begin
            if (req.addr == l1_hdlc_pkg::ADDR_CMDX) begin
                st_nxt.ciTx = req.wdata[3:0];
            end else if (req.addr == l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST) begin
                st_nxt.term_id_reg_first = req.wdata;
            end else if (req.addr == l1_hdlc_pkg::ADDR_TERM_ID_REG_SECOND) begin
                st_nxt.term_id_reg_second = req.wdata;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SERVICE_POINT_REG_FIRST) begin
                st_nxt.service_point_reg_first = req.wdata;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SERVICE_POINT_REG_SECOND) begin
                st_nxt.service_point_reg_second = req.wdata;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SPRT) begin
                st_nxt.sport = req.wdata;
            end else if (req.addr == l1_hdlc_pkg::ADDR_MODE) begin
                st_nxt.mode = req.wdata;
            end
        end
        // ************************************************************
        // read data, valid only the cycle after the strobe
        // ************************************************************
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            if (req.addr == l1_hdlc_pkg::ADDR_ISTA) begin
                st_nxt.rdata = st_r.ista;
            end else if (req.addr == l1_hdlc_pkg::ADDR_EXTD) begin
                st_nxt.rdata = st_r.ext;
            end else if (req.addr == l1_hdlc_pkg::ADDR_CMDX) begin
                st_nxt.rdata = {4'h0, st_r.ciTx};
            end else if (req.addr == l1_hdlc_pkg::ADDR_CIRX) begin
                st_nxt.rdata = {4'h0, st_r.ciRx};
            end else if (req.addr == l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST) begin
                st_nxt.rdata = st_r.term_id_reg_first;
            end else if (req.addr == l1_hdlc_pkg::ADDR_TERM_ID_REG_SECOND) begin
                st_nxt.rdata = st_r.term_id_reg_second;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SERVICE_POINT_REG_FIRST) begin
                st_nxt.rdata = st_r.service_point_reg_first;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SERVICE_POINT_REG_SECOND) begin
                st_nxt.rdata = st_r.service_point_reg_second;
            end else if (req.addr == l1_hdlc_pkg::ADDR_SPRT) begin
                st_nxt.rdata = st_r.sport;
            end else if (req.addr == l1_hdlc_pkg::ADDR_STAT) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[l1_hdlc_pkg::STAT_TXBLK] = ~txFifoWriteEnable;
            end else if (req.addr == l1_hdlc_pkg::ADDR_MODE) begin
                st_nxt.rdata = st_r.mode;
            end else if (req.addr == l1_hdlc_pkg::ADDR_STA2) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[l1_hdlc_pkg::STA2_TIMER_RECOVERY_FLAG] = timerRecoveryFlag;
            end
        end
        // ************************************************************
        // data paths
        // ************************************************************
        // loop off drops back to the normal line, layer 1 sees deactivated idle again
        st_nxt.upOut = st_r.sport[l1_hdlc_pkg::SP_TLOOP] ? upSync : 1'b1;
        case (st_r.sport[l1_hdlc_pkg::SP_BSEL_LO +: 2])
            l1_hdlc_pkg::BSEL_SYNC: st_nxt.bOut = {1'b0, bChanIn[0]};
            l1_hdlc_pkg::BSEL_SLOT: st_nxt.bOut = {bChanIn[1], 1'b0};
            default: st_nxt.bOut = bChanIn;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{ista: 8'h00, ext: 8'h00, ciTx: l1_hdlc_pkg::CI_DEACT_IDLE, ciRx: 4'h0,
                      term_id_reg_first: l1_hdlc_pkg::TEI_BROADCAST, term_id_reg_second: l1_hdlc_pkg::TEI_BROADCAST,
                      service_point_reg_first: 8'h00, service_point_reg_second: 8'h00, sport: 8'h00, mode: 8'h00, rxCnt: 6'h00,
                      rdata: 8'h00, upOut: 1'b1, bOut: 2'b00};
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign busRdata = st_r.rdata;
    assign commandIndicateCh0Tx = st_r.ciTx;
    assign downstreamOut = st_r.upOut;
    assign bChanOut = st_r.bOut;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence ciStep;
        clkEn && ciChanged && !rdIsta;
    endsequence
    a_l1_change_flag: assert property (ciStep |=> st_r.ista[l1_hdlc_pkg::ISTA_L1CHG])
        else $error("layer-1 change not flagged");
    a_timer_auto_only: assert property (clkEn && !st_r.mode[0] && !rdIsta && !$past(rdIsta)
        && !st_r.ista[3] |=> !st_r.ista[3])
        else $error("timer flag outside auto mode");
    a_remote_flag: assert property (clkEn && remoteRxChange |=> st_r.ista[5])
        else $error("remote change not flagged");
    a_ext_summary: assert property (clkEn && |extEvt |=> st_r.ista[0] && st_r.ext != 8'h00)
        else $error("extended summary missing");
    a_end_flag: assert property (clkEn && rxFrameEnd |=> st_r.ista[7] && st_r.rxCnt == 6'h00)
        else $error("message end not flagged");
    a_pool_count: assert property (st_r.rxCnt < l1_hdlc_pkg::RX_POOL_CNT)
        else $error("receive count beyond pool");
    a_loop_path: assert property (clkEn && st_r.sport[7] |=> downstreamOut == $past(upSync))
        else $error("test loop path broken");
    a_loop_off: assert property (clkEn && !st_r.sport[7] |=> downstreamOut)
        else $error("loop off not idle");
    a_bsel_net: assert property (clkEn && st_r.sport[1:0] == 2'h0 |=> bChanOut == $past(bChanIn))
        else $error("b-channel network path broken");
endmodule

// ==== test/layer2_host_model.sv ====
// host model: register port master and layer-1 service routines
`timescale 1ns/1ps
module layer2_host_model (
    input wire logic sys_clk,
    output logic [3:0] busAddr,
    output logic [7:0] busWdata,
    output logic busWr,
    output logic busRd,
    input wire logic [7:0] busRdata
);
    initial begin
        busAddr = 4'h0;
        busWdata = 8'h00;
        busWr = 1'b0;
        busRd = 1'b0;
    end
    // ************************************************************
    // bus cycles
    // ************************************************************
    // idle address, and idle data after a write, show the inverse so a stale value never passes for a live one
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge sys_clk);
        busWr <= 1'b0;
        busAddr <= ~a;
        busWdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge sys_clk);
        busRd <= 1'b0;
        busAddr <= ~a;
        @(posedge sys_clk);
        d = busRdata;
    endtask
    // ************************************************************
    // layer-1 and layer-2 routines
    // ************************************************************
    // polling is bounded by a try count; no answer means a dead layer 1
    task automatic resetL1(input int tries, output logic bad);
        logic [7:0] s;
        bad = 1'b1;
        wr(l1_hdlc_pkg::ADDR_CMDX, {4'h0, l1_hdlc_pkg::CI_SOFT_RESET});
        for (int i = 0; i < tries && bad; i++) begin
            rd(l1_hdlc_pkg::ADDR_CIRX, s);
            bad = (s[3:0] !== l1_hdlc_pkg::CI_READY_IDLE);
        end
        if (!bad) begin
            wr(l1_hdlc_pkg::ADDR_CMDX, {4'h0, l1_hdlc_pkg::CI_DEACT_IDLE});
        end
    endtask
    task automatic serviceL1();
        logic [7:0] s;
        rd(l1_hdlc_pkg::ADDR_CIRX, s);
        if (s[3:0] === l1_hdlc_pkg::CI_PEND_DEACT) begin
            wr(l1_hdlc_pkg::ADDR_CMDX, {4'h0, l1_hdlc_pkg::CI_DEACT_IDLE});
        end else if (s[3:0] === l1_hdlc_pkg::CI_ACT_IND) begin
            wr(l1_hdlc_pkg::ADDR_CMDX, {4'h0, l1_hdlc_pkg::CI_ACT_REQ});
        end
    endtask
    // receive events are left alone while a timer or protocol error is pending
    task automatic rxService(output logic take);
        logic [7:0] s;
        logic [7:0] e;
        rd(l1_hdlc_pkg::ADDR_ISTA, s);
        rd(l1_hdlc_pkg::ADDR_EXTD, e);
        take = (s[l1_hdlc_pkg::ISTA_RXEND] | s[l1_hdlc_pkg::ISTA_POOLF]) && !s[l1_hdlc_pkg::ISTA_TIMER]
            && !e[l1_hdlc_pkg::EXT_PROTERR];
    endtask
    function automatic int ctrlBytes(input logic mod128);
        return mod128 ? 2 : 1;
    endfunction
    // a clockless layer 1 is woken first so the loop has clocks to run on
    task automatic loopOn(input logic clocksOff);
        if (clocksOff) begin
            wr(l1_hdlc_pkg::ADDR_CMDX, {4'h0, l1_hdlc_pkg::CI_ACT_REQ});
        end
        wr(l1_hdlc_pkg::ADDR_SPRT, 8'h80);
    endtask
    task automatic initL2();
        wr(l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST, l1_hdlc_pkg::TEI_BROADCAST);
        wr(l1_hdlc_pkg::ADDR_TERM_ID_REG_SECOND, l1_hdlc_pkg::TEI_BROADCAST);
    endtask
endmodule

// ==== test/l1_hdlc_service_tb_top.sv ====
// testbench top for the layer-1/hdlc service block
`timescale 1ns/1ps
module l1_hdlc_service_tb_top;
    logic sys_clk, arst_n, clkEn, upstreamIn, downstreamOut, txFifoWriteEnable, timerRecoveryFlag, l1Alive, bad;
    logic busWr, busRd;
    logic [3:0] busAddr, ciTx, ciRx;
    logic [7:0] busWdata, busRdata, d;
    logic [1:0] bChanIn, bChanOut;
    logic [5:0] ev, extEvt;
    logic [5:0] evMask[4] = '{6'h01, 6'h02, 6'h04, 6'h08};
    logic [7:0] evExp[4] = '{8'h08, 8'h20, 8'h10, 8'h02};
    int n_fail, n_compared;
    layer2_host_model i_host (.sys_clk(sys_clk), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
        .busRd(busRd), .busRdata(busRdata));
    l1_hdlc_service i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .commandIndicateCh0Tx(ciTx),
        .commandIndicateCh0Rx(ciRx), .upstreamIn(upstreamIn), .downstreamOut(downstreamOut), .bChanIn(bChanIn),
        .bChanOut(bChanOut), .hdlcTimerTick(ev[0]), .remoteRxChange(ev[1]), .txPoolReady(ev[2]),
        .syncXferEvt(ev[3]), .extEvt(extEvt), .rxByte(ev[4]), .rxFrameEnd(ev[5]),
        .txFifoWriteEnable(txFifoWriteEnable), .timerRecoveryFlag(timerRecoveryFlag));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // layer-1 stand-in: answers a soft reset with ready-idle only while alive
    always @(posedge sys_clk) begin
        if (l1Alive && ciTx === l1_hdlc_pkg::CI_SOFT_RESET) ciRx <= l1_hdlc_pkg::CI_READY_IDLE;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkReg(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd(a, v);
        check(what, exp, v);
    endtask
    task automatic pulse(input logic [5:0] m, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ev <= m;
            @(posedge sys_clk);
            ev <= 6'h00;
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // the whole sequence needs about 330 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        {arst_n, l1Alive, ev, extEvt, timerRecoveryFlag} = '0;
        {clkEn, upstreamIn, txFifoWriteEnable} = 3'h7;
        ciRx = 4'h5;
        bChanIn = 2'h1;
        repeat (12) @(posedge sys_clk);
        check("rst tx", 8'h0F, {4'h0, ciTx});
        check("rst out", 8'h04, {5'h0, downstreamOut, bChanOut} | busRdata);
        arst_n <= 1'b1;
        chkReg("term_id_reg_first rst", l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST, 8'hFF);
        chkReg("unmapped rd", 4'hC, 8'h00);
        i_host.wr(4'hD, 8'h5A);
        chkReg("unmapped wr", 4'hD, 8'h00);
        for (int i = 0; i < 4; i++) i_host.wr(l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST + 4'(i), 8'h40 + 8'(i));
        for (int i = 0; i < 4; i++) chkReg("id reg", l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST + 4'(i), 8'h40 + 8'(i));
        i_host.initL2();
        chkReg("term_id_reg_first", l1_hdlc_pkg::ADDR_TERM_ID_REG_FIRST, 8'hFF);
        chkReg("term_id_reg_second", l1_hdlc_pkg::ADDR_TERM_ID_REG_SECOND, 8'hFF);
        chkReg("service_point_reg_first", l1_hdlc_pkg::ADDR_SERVICE_POINT_REG_FIRST, 8'h42);
        $display("test registers done");
        l1Alive <= 1'b1;
        i_host.resetL1(8, bad);
        @(posedge sys_clk);
        check("l1 alive", 8'h00, {7'h0, bad});
        check("release", 8'h0F, {4'h0, ciTx});
        l1Alive <= 1'b0;
        ciRx <= 4'h5;
        i_host.resetL1(4, bad);
        check("l1 dead", 8'h01, {7'h0, bad});
        i_host.rd(l1_hdlc_pkg::ADDR_ISTA, d);
        ciRx <= l1_hdlc_pkg::CI_ACT_IND;
        repeat (6) @(posedge sys_clk);
        chkReg("l1 change", l1_hdlc_pkg::ADDR_ISTA, 8'h04);
        i_host.serviceL1();
        @(posedge sys_clk);
        check("act req", 8'h08, {4'h0, ciTx});
        ciRx <= l1_hdlc_pkg::CI_PEND_DEACT;
        repeat (6) @(posedge sys_clk);
        i_host.serviceL1();
        @(posedge sys_clk);
        check("deact", 8'h0F, {4'h0, ciTx});
        $display("test layer1 done");
        i_host.rd(l1_hdlc_pkg::ADDR_ISTA, d);
        pulse(6'h01, 1);
        chkReg("timer no auto", l1_hdlc_pkg::ADDR_ISTA, 8'h00);
        i_host.wr(l1_hdlc_pkg::ADDR_MODE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            pulse(evMask[i], 1);
            chkReg("ista evt", l1_hdlc_pkg::ADDR_ISTA, evExp[i]);
        end
        chkReg("ista clear", l1_hdlc_pkg::ADDR_ISTA, 8'h00);
        @(posedge sys_clk);
        extEvt <= 6'h21;
        @(posedge sys_clk);
        extEvt <= 6'h00;
        chkReg("ista ext", l1_hdlc_pkg::ADDR_ISTA, 8'h01);
        chkReg("ext reg", l1_hdlc_pkg::ADDR_EXTD, 8'h21);
        chkReg("ext clear", l1_hdlc_pkg::ADDR_EXTD, 8'h00);
        pulse(6'h10, 31);
        // the ext summary kept setting while the ext register was pending
        chkReg("pool 31", l1_hdlc_pkg::ADDR_ISTA, 8'h01);
        pulse(6'h10, 1);
        chkReg("pool 32", l1_hdlc_pkg::ADDR_ISTA, 8'h40);
        pulse(6'h10, 5);
        pulse(6'h20, 1);
        chkReg("msg end", l1_hdlc_pkg::ADDR_ISTA, 8'h80);
        pulse(6'h21, 1);
        i_host.rxService(bad);
        check("rx blocked", 8'h00, {7'h0, bad});
        pulse(6'h20, 1);
        i_host.rxService(bad);
        check("rx taken", 8'h01, {7'h0, bad});
        check("ctrl mod8", 8'h01, 8'(i_host.ctrlBytes(1'b0)));
        check("ctrl mod128", 8'h02, 8'(i_host.ctrlBytes(1'b1)));
        $display("test events done");
        for (int j = 0; j < 2; j++) begin
            txFifoWriteEnable <= 1'(j);
            timerRecoveryFlag <= 1'(1 - j);
            repeat (3) @(posedge sys_clk);
            i_host.rd(l1_hdlc_pkg::ADDR_STAT, d);
            check("fifo blocked", {1'b0, ~1'(j), 6'h00}, d & 8'h40);
            i_host.rd(l1_hdlc_pkg::ADDR_STA2, d);
            check("recovery", {4'h0, 1'(1 - j), 3'h0}, d & 8'h08);
        end
        i_host.loopOn(1'b1);
        for (int j = 0; j < 2; j++) begin
            upstreamIn <= 1'(j);
            repeat (5) @(posedge sys_clk);
            check("loop", 8'(j), {7'h0, downstreamOut});
        end
        upstreamIn <= 1'b0;
        i_host.wr(l1_hdlc_pkg::ADDR_SPRT, 8'h00);
        repeat (5) @(posedge sys_clk);
        check("loop off", 8'h01, {7'h0, downstreamOut});
        for (int k = 0; k < 8; k++) begin
            bChanIn <= 2'(1 + k / 4);
            i_host.wr(l1_hdlc_pkg::ADDR_SPRT, 8'(k % 4));
            repeat (2) @(posedge sys_clk);
            d = (k % 4 == 1) ? {7'h0, bChanIn[0]} : (k % 4 == 2) ? {6'h0, bChanIn[1], 1'b0} : {6'h0, bChanIn};
            check("b route", d, {6'h0, bChanOut});
        end
        $display("test status and port done");
        wrap_up();
    end
endmodule
